// file: src/ird_pkg.sv
package ird_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_STRANDS = 32;
  localparam int VC_W = 5;
  localparam int VEC_W = 6;
  localparam int RX_W = 64;
  localparam int NUM_SRC = 2;
  localparam int ADDR_W = 12;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] OFF_SEL = 12'h000;
  localparam logic [11:0] OFF_RX_LO = 12'h004;
  localparam logic [11:0] OFF_RX_HI = 12'h008;
  localparam logic [11:0] OFF_INVEC = 12'h00c;
  localparam logic [11:0] OFF_XCALL = 12'h010;
  localparam logic [11:0] OFF_MONDO_VEC = 12'h014;
  localparam logic [11:0] OFF_BUSY = 12'h018;
  localparam logic [11:0] OFF_PAY0_LO = 12'h020;
  localparam logic [11:0] OFF_PAY0_HI = 12'h024;
  localparam logic [11:0] OFF_PAY1_LO = 12'h028;
  localparam logic [11:0] OFF_PAY1_HI = 12'h02c;
  localparam logic [11:0] OFF_ROUTE_ERR = 12'h034;
  localparam logic [11:0] OFF_ROUTE_SER = 12'h038;
  localparam logic [11:0] OFF_MASK_ERR = 12'h044;
  localparam logic [11:0] OFF_MASK_SER = 12'h048;

  // ************************************************************
  // Field positions and codes
  // ************************************************************
  localparam int ROUTE_CPU_LSB = 8;
  localparam int XCALL_TYPE_LSB = 16;
  localparam logic [1:0] XCALL_TYPE_INT = 2'h0;
  localparam int MASK_BIT = 2;
  localparam int CLEAR_BIT = 1;
  localparam int PEND_BIT = 0;
  localparam int INVEC_VALID_BIT = 6;
  localparam int SRC_ERR = 0;
  localparam int SRC_SER = 1;

  typedef struct packed {
    logic [VC_W-1:0] cpu;
    logic [VEC_W-1:0] vec;
  } ird_target_s;

  typedef struct packed {
    logic valid;
    ird_target_s tgt;
  } ird_dispatch_s;

  typedef struct packed {
    logic valid;
    logic [VC_W-1:0] vc;
    logic [RX_W-1:0] data0;
    logic [RX_W-1:0] data1;
  } ird_mondo_s;

  typedef enum logic [1:0] {
    SRC_IDLE,
    SRC_MASKED,
    SRC_PENDING
  } ird_src_e;

endpackage

// file: src/ird_top.sv
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Function
// - Writing zero to one half clears those 32 bits
// - Vector read returns top index, clears it
// - Bit 63 highest, bit 0 lowest priority
// - Set on already-set bit is silently lost
// - Receive write clears bits written zero
// - Same-cycle set beats any clear
// - Idle strand: ack, busy, payload, vector bit
// - Busy strand: every bus interrupt gets NACK
// - Clearing busy bit returns strand to idle
// - Idle source: mask, set routed vector bit
// - Masked source event goes pending, once only
// - Unmask: idle, or deliver pending and remask
// - Falling external pin raises serial source
// - Bus, serial, memory errors raise error source
// - Every bus interrupt uses busy state machine
// - Dispatch write sets vector at destination strand
// - Dispatch writes take effect in store order
// - Test port dispatch also raises cross-calls
// - Sixty-four independent bits per strand
// - Busy bits set after reset
// - Mask set after reset and on delivery
// - Writing one to clear drops pending flag
module ird_top #(
  parameter int NUM_STRANDS = ird_pkg::NUM_STRANDS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ird_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ird_pkg::ird_mondo_s mondo_req,
  output logic mondo_ack,
  output logic mondo_nack,
  input wire ird_pkg::ird_dispatch_s tap_dispatch,
  input wire logic err_bus_detect,
  input wire logic err_serial_detect,
  input wire logic err_mem_underflow,
  input wire logic external_interrupt_n,
  output logic [NUM_STRANDS-1:0] rx_pending
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [ird_pkg::RX_W-1:0] vec_bit(input logic [ird_pkg::VEC_W-1:0] v);
    vec_bit = {{(ird_pkg::RX_W-1){1'b0}}, 1'b1} << v;
  endfunction

  // Returns {any, index}; later hits overwrite so bit 63 wins
  function automatic logic [ird_pkg::VEC_W:0] prio_index(input logic [ird_pkg::RX_W-1:0] rx);
    prio_index = '0;
    for (int i = 0; i < ird_pkg::RX_W; i++) begin
      if (rx[i]) begin
        prio_index = {1'b1, ird_pkg::VEC_W'(i)};
      end
    end
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  logic [ird_pkg::RX_W-1:0] rx_reg [NUM_STRANDS];
  logic [ird_pkg::RX_W-1:0] rx_next [NUM_STRANDS];
  logic [ird_pkg::RX_W-1:0] set_vec [NUM_STRANDS];
  logic [ird_pkg::RX_W-1:0] pay0_reg [NUM_STRANDS];
  logic [ird_pkg::RX_W-1:0] pay1_reg [NUM_STRANDS];
  logic [NUM_STRANDS-1:0] busy_reg;
  logic [NUM_STRANDS-1:0] busy_next;
  logic [ird_pkg::VC_W-1:0] sel_reg;
  logic [ird_pkg::VEC_W-1:0] mondo_vec_reg;
  ird_pkg::ird_target_s route_reg [ird_pkg::NUM_SRC];
  ird_pkg::ird_src_e src_reg [ird_pkg::NUM_SRC];
  ird_pkg::ird_src_e src_next [ird_pkg::NUM_SRC];
  logic [ird_pkg::NUM_SRC-1:0] src_evt;
  logic [ird_pkg::NUM_SRC-1:0] src_fire;
  logic [ird_pkg::NUM_SRC-1:0] mask_wr;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [31:0] rd_val;
  logic rd_err;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_s3_reg;
  logic ext_fall;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ************************************************************
  // APB slave: one wait state so read data leaves a flip-flop
  // ************************************************************
  logic wr_done;
  logic rd_done;
  logic sel_ok;
  logic [ird_pkg::RX_W-1:0] sel_rx;
  logic invec_clr;
  logic xcall_fire;
  ird_pkg::ird_target_s xcall_tgt;

  assign wr_done = psel && penable && pready_reg && pwrite;
  assign rd_done = psel && penable && pready_reg && !pwrite;
  assign sel_ok = 32'(sel_reg) < NUM_STRANDS;
  assign sel_rx = sel_ok ? rx_reg[sel_reg] : '0;
  // Index cleared is the one returned, even if a higher bit arrived in between
  assign invec_clr = rd_done && paddr == ird_pkg::OFF_INVEC && prdata_reg[ird_pkg::INVEC_VALID_BIT];
  assign xcall_tgt = {pwdata[ird_pkg::ROUTE_CPU_LSB +: ird_pkg::VC_W], pwdata[ird_pkg::VEC_W-1:0]};
  // Reset, idle and resume dispatch types are not handled by this block
  assign xcall_fire = wr_done && paddr == ird_pkg::OFF_XCALL
                      && pwdata[ird_pkg::XCALL_TYPE_LSB +: 2] == ird_pkg::XCALL_TYPE_INT;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    case (paddr)
      ird_pkg::OFF_SEL: rd_val = 32'(sel_reg);
      ird_pkg::OFF_RX_LO: rd_val = sel_rx[31:0];
      ird_pkg::OFF_RX_HI: rd_val = sel_rx[63:32];
      ird_pkg::OFF_INVEC: rd_val = 32'(prio_index(sel_rx));
      ird_pkg::OFF_XCALL: rd_val = '0;
      ird_pkg::OFF_MONDO_VEC: rd_val = 32'(mondo_vec_reg);
      ird_pkg::OFF_BUSY: rd_val = 32'(busy_reg);
      ird_pkg::OFF_PAY0_LO: rd_val = sel_ok ? pay0_reg[sel_reg][31:0] : '0;
      ird_pkg::OFF_PAY0_HI: rd_val = sel_ok ? pay0_reg[sel_reg][63:32] : '0;
      ird_pkg::OFF_PAY1_LO: rd_val = sel_ok ? pay1_reg[sel_reg][31:0] : '0;
      ird_pkg::OFF_PAY1_HI: rd_val = sel_ok ? pay1_reg[sel_reg][63:32] : '0;
      ird_pkg::OFF_ROUTE_ERR: rd_val = (32'(route_reg[ird_pkg::SRC_ERR].cpu) << ird_pkg::ROUTE_CPU_LSB)
                                       | 32'(route_reg[ird_pkg::SRC_ERR].vec);
      ird_pkg::OFF_ROUTE_SER: rd_val = (32'(route_reg[ird_pkg::SRC_SER].cpu) << ird_pkg::ROUTE_CPU_LSB)
                                       | 32'(route_reg[ird_pkg::SRC_SER].vec);
      ird_pkg::OFF_MASK_ERR: begin
        rd_val[ird_pkg::MASK_BIT] = src_reg[ird_pkg::SRC_ERR] != ird_pkg::SRC_IDLE;
        rd_val[ird_pkg::PEND_BIT] = src_reg[ird_pkg::SRC_ERR] == ird_pkg::SRC_PENDING;
      end
      ird_pkg::OFF_MASK_SER: begin
        rd_val[ird_pkg::MASK_BIT] = src_reg[ird_pkg::SRC_SER] != ird_pkg::SRC_IDLE;
        rd_val[ird_pkg::PEND_BIT] = src_reg[ird_pkg::SRC_SER] == ird_pkg::SRC_PENDING;
      end
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (psel && penable && !pready_reg) begin
      pready_reg <= 1'b1;
      prdata_reg <= pwrite ? '0 : rd_val;
      pslverr_reg <= rd_err;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= '0;
      mondo_vec_reg <= '0;
      route_reg[ird_pkg::SRC_ERR] <= '0;
      route_reg[ird_pkg::SRC_SER] <= '0;
    end else if (wr_done) begin
      if (paddr == ird_pkg::OFF_SEL) begin
        sel_reg <= pwdata[ird_pkg::VC_W-1:0];
      end
      if (paddr == ird_pkg::OFF_MONDO_VEC) begin
        mondo_vec_reg <= pwdata[ird_pkg::VEC_W-1:0];
      end
      if (paddr == ird_pkg::OFF_ROUTE_ERR) begin
        route_reg[ird_pkg::SRC_ERR] <= xcall_tgt;
      end
      if (paddr == ird_pkg::OFF_ROUTE_SER) begin
        route_reg[ird_pkg::SRC_SER] <= xcall_tgt;
      end
    end
  end

  // ************************************************************
  // Bus interrupt (mondo) busy handling
  // ************************************************************
  logic mondo_vc_ok;
  logic mondo_take;

  assign mondo_vc_ok = 32'(mondo_req.vc) < NUM_STRANDS;
  assign mondo_take = mondo_req.valid && mondo_vc_ok && !busy_reg[mondo_req.vc];
  assign mondo_ack = mondo_take;
  assign mondo_nack = mondo_req.valid && !mondo_take;

  always_comb begin
    busy_next = busy_reg;
    if (wr_done && paddr == ird_pkg::OFF_BUSY) begin
      busy_next = busy_reg & ~pwdata[NUM_STRANDS-1:0];
    end
    if (mondo_take) begin
      busy_next[mondo_req.vc] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= '1;
    end else begin
      busy_reg <= busy_next;
    end
  end

  // ************************************************************
  // Internal sources: external pin sync and error events
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
      ext_s3_reg <= 1'b1;
    end else begin
      ext_s1_reg <= external_interrupt_n;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  assign ext_fall = ext_s3_reg && !ext_s2_reg;
  assign src_evt[ird_pkg::SRC_ERR] = err_bus_detect || err_serial_detect || err_mem_underflow;
  assign src_evt[ird_pkg::SRC_SER] = ext_fall;
  assign mask_wr[ird_pkg::SRC_ERR] = wr_done && paddr == ird_pkg::OFF_MASK_ERR;
  assign mask_wr[ird_pkg::SRC_SER] = wr_done && paddr == ird_pkg::OFF_MASK_SER;

  generate
    for (genvar i = 0; i < ird_pkg::NUM_SRC; i++) begin : g_src
      always_comb begin
        src_next[i] = src_reg[i];
        src_fire[i] = 1'b0;
        case (src_reg[i])
          ird_pkg::SRC_IDLE: begin
            if (src_evt[i]) begin
              src_fire[i] = 1'b1;
              src_next[i] = ird_pkg::SRC_MASKED;
            end else if (mask_wr[i] && pwdata[ird_pkg::MASK_BIT]) begin
              src_next[i] = ird_pkg::SRC_MASKED;
            end
          end
          ird_pkg::SRC_MASKED: begin
            if (mask_wr[i] && !pwdata[ird_pkg::MASK_BIT]) begin
              // An event in the unmasking cycle is delivered, never lost
              src_fire[i] = src_evt[i];
              src_next[i] = src_evt[i] ? ird_pkg::SRC_MASKED : ird_pkg::SRC_IDLE;
            end else if (src_evt[i]) begin
              src_next[i] = ird_pkg::SRC_PENDING;
            end
          end
          ird_pkg::SRC_PENDING: begin
            if (mask_wr[i] && !pwdata[ird_pkg::MASK_BIT]) begin
              src_fire[i] = 1'b1;
              src_next[i] = ird_pkg::SRC_MASKED;
            end else if (mask_wr[i] && pwdata[ird_pkg::CLEAR_BIT] && !src_evt[i]) begin
              src_next[i] = ird_pkg::SRC_MASKED;
            end
          end
          default: src_next[i] = ird_pkg::SRC_MASKED;
        endcase
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          src_reg[i] <= ird_pkg::SRC_MASKED;
        end else begin
          src_reg[i] <= src_next[i];
        end
      end

      pend_go_a: assert property (
        src_reg[i] == ird_pkg::SRC_MASKED && src_evt[i] && !mask_wr[i] |=> src_reg[i] == ird_pkg::SRC_PENDING)
        else $error("masked source event did not go pending");

      unmask_fire_a: assert property (
        src_reg[i] == ird_pkg::SRC_PENDING && mask_wr[i] && !pwdata[ird_pkg::MASK_BIT]
        |-> src_fire[i] ##1 src_reg[i] == ird_pkg::SRC_MASKED)
        else $error("pending source not delivered on unmask");
    end
  endgenerate

  // ************************************************************
  // Receive registers, one per strand
  // ************************************************************
  generate
    for (genvar s = 0; s < NUM_STRANDS; s++) begin : g_strand
      logic [ird_pkg::RX_W-1:0] clr_vec;

      always_comb begin
        set_vec[s] = '0;
        if (mondo_take && mondo_req.vc == ird_pkg::VC_W'(s)) begin
          set_vec[s] = set_vec[s] | vec_bit(mondo_vec_reg);
        end
        if (xcall_fire && xcall_tgt.cpu == ird_pkg::VC_W'(s)) begin
          set_vec[s] = set_vec[s] | vec_bit(xcall_tgt.vec);
        end
        if (tap_dispatch.valid && tap_dispatch.tgt.cpu == ird_pkg::VC_W'(s)) begin
          set_vec[s] = set_vec[s] | vec_bit(tap_dispatch.tgt.vec);
        end
        for (int k = 0; k < ird_pkg::NUM_SRC; k++) begin
          if (src_fire[k] && route_reg[k].cpu == ird_pkg::VC_W'(s)) begin
            set_vec[s] = set_vec[s] | vec_bit(route_reg[k].vec);
          end
        end
      end

      always_comb begin
        clr_vec = '0;
        if (sel_reg == ird_pkg::VC_W'(s)) begin
          if (wr_done && paddr == ird_pkg::OFF_RX_LO) begin
            clr_vec[31:0] = ~pwdata;
          end
          if (wr_done && paddr == ird_pkg::OFF_RX_HI) begin
            clr_vec[63:32] = ~pwdata;
          end
          if (invec_clr) begin
            clr_vec = clr_vec | vec_bit(prdata_reg[ird_pkg::VEC_W-1:0]);
          end
        end
        // A set on an already-set bit merges away with no trace
        rx_next[s] = (rx_reg[s] & ~clr_vec) | set_vec[s];
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_reg[s] <= '0;
        end else begin
          rx_reg[s] <= rx_next[s];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pay0_reg[s] <= '0;
          pay1_reg[s] <= '0;
        end else if (mondo_take && mondo_req.vc == ird_pkg::VC_W'(s)) begin
          pay0_reg[s] <= mondo_req.data0;
          pay1_reg[s] <= mondo_req.data1;
        end
      end

      assign rx_pending[s] = |rx_reg[s];
    end
  endgenerate

  // ************************************************************
  // Checks
  // ************************************************************
  sequence mondo_idle_hit;
    mondo_req.valid && mondo_vc_ok && !busy_reg[mondo_req.vc];
  endsequence

  sequence mondo_busy_hit;
    mondo_req.valid && mondo_vc_ok && busy_reg[mondo_req.vc];
  endsequence

  mondo_accept_a: assert property (
    mondo_idle_hit |-> mondo_ack && !mondo_nack ##1 busy_reg[$past(mondo_req.vc)]
    && pay0_reg[$past(mondo_req.vc)] == $past(mondo_req.data0)
    && rx_reg[$past(mondo_req.vc)][$past(mondo_vec_reg)])
    else $error("idle mondo not accepted and recorded");

  mondo_reject_a: assert property (
    mondo_busy_hit |-> mondo_nack && !mondo_ack ##1 pay0_reg[$past(mondo_req.vc)] == $past(pay0_reg[mondo_req.vc]))
    else $error("busy mondo not refused");

  busy_clear_a: assert property (
    wr_done && paddr == ird_pkg::OFF_BUSY && pwdata[0] && !(mondo_take && mondo_req.vc == '0) |=> !busy_reg[0])
    else $error("busy bit not cleared by write");

  invec_pick_a: assert property (
    psel && penable && !pready && !pwrite && paddr == ird_pkg::OFF_INVEC && sel_ok && |sel_rx
    |=> prdata[ird_pkg::INVEC_VALID_BIT] && ($past(sel_rx) >> prdata[ird_pkg::VEC_W-1:0]) == 64'h1)
    else $error("incoming vector not highest set bit");

  top_prio_a: assert property (
    psel && penable && !pready && !pwrite && paddr == ird_pkg::OFF_INVEC && sel_rx[63]
    |=> prdata[ird_pkg::VEC_W-1:0] == 6'h3f)
    else $error("bit 63 not ranked highest");

  set_wins_a: assert property (
    sel_ok |=> (rx_reg[$past(sel_reg)] & $past(set_vec[sel_reg])) == $past(set_vec[sel_reg]))
    else $error("set lost against clear");

  zero_write_a: assert property (
    wr_done && paddr == ird_pkg::OFF_RX_LO && pwdata == '0 && sel_ok && set_vec[sel_reg] == '0 && !invec_clr
    |=> rx_reg[$past(sel_reg)][31:0] == '0)
    else $error("zero write did not clear receive bits");

  ext_edge_a: assert property (
    ext_s3_reg && !ext_s2_reg && src_reg[ird_pkg::SRC_SER] == ird_pkg::SRC_IDLE
    |-> src_fire[ird_pkg::SRC_SER] ##1 src_reg[ird_pkg::SRC_SER] == ird_pkg::SRC_MASKED)
    else $error("pin edge did not raise serial source");

  xcall_set_a: assert property (
    xcall_fire && 32'(xcall_tgt.cpu) < NUM_STRANDS |=> rx_reg[$past(xcall_tgt.cpu)][$past(xcall_tgt.vec)])
    else $error("dispatch did not set destination bit");

endmodule

// file: testbench/ird_mondo_agent.sv
`timescale 1ns/1ps
module ird_mondo_agent (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [ird_pkg::VC_W-1:0] vc,
  input wire logic [63:0] d0,
  input wire logic ack,
  input wire logic nack,
  output ird_pkg::ird_mondo_s req,
  output int nacks
);
  // ************************************************************
  // Bus requester
  // ************************************************************
  // A refused request stays up and is offered again each cycle until taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= '0;
      nacks <= 0;
    end else if (go) begin
      req <= {1'b1, vc, d0, ~d0};
    end else if (req.valid && ack) begin
      // Released lines show the inverse, never the old payload
      req <= {1'b0, ~req.vc, ~req.data0, ~req.data1};
    end else if (req.valid && nack) begin
      nacks <= nacks + 1;
    end
  end
endmodule

// file: testbench/ird_tb_top.sv
`timescale 1ns/1ps
module ird_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mondo_ack, mondo_nack;
  logic err_bus, err_ser, err_mem, ext_n, go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v, rx_pending;
  logic [4:0] gvc;
  logic [63:0] gd0;
  logic rd_e;
  ird_pkg::ird_mondo_s mondo_req;
  ird_pkg::ird_dispatch_s tap_dispatch;
  int nacks, num_errors, comparisons;

  ird_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mondo_req(mondo_req), .mondo_ack(mondo_ack), .mondo_nack(mondo_nack), .tap_dispatch(tap_dispatch),
    .err_bus_detect(err_bus), .err_serial_detect(err_ser), .err_mem_underflow(err_mem),
    .external_interrupt_n(ext_n), .rx_pending(rx_pending));
  ird_mondo_agent agent (.pclk(pclk), .presetn(presetn), .go(go), .vc(gvc), .d0(gd0),
    .ack(mondo_ack), .nack(mondo_nack), .req(mondo_req), .nacks(nacks));

  // ************************************************************
  // Helpers
  // ************************************************************
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end

  task automatic summarize();
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Answer is taken at the edge where pready is sampled high; an idle edge follows
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask

  task automatic xc(input int s, input int v);
    wr(ird_pkg::OFF_XCALL, (32'(s) << 8) | 32'(v));
  endtask

  // 0 bus, 1 serial, 2 memory error, 3 pin, 4 test port to strand 1 vector 3 with serial error
  task automatic pulse(input int k);
    if (k == 0) err_bus <= 1;
    if (k == 1 || k == 4) err_ser <= 1;
    if (k == 2) err_mem <= 1;
    if (k == 3) ext_n <= 0;
    if (k == 4) tap_dispatch <= {1'b1, 5'h01, 6'h03};
    @(posedge pclk);
    {err_bus, err_ser, err_mem} <= 3'h0;
    tap_dispatch <= '0;
    repeat (2) @(posedge pclk);
    ext_n <= 1;
    repeat (4) @(posedge pclk);
  endtask

  task automatic send(input logic [63:0] d);
    go <= 1;
    gvc <= 5'h03;
    gd0 <= d;
    @(posedge pclk);
    go <= 0;
    repeat (6) @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    summarize();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    {presetn, psel, penable, pwrite, err_bus, err_ser, err_mem, go} = 8'h0;
    {paddr, pwdata, gvc, gd0} = '0;
    tap_dispatch = '0;
    ext_n = 1;
    num_errors = 0;
    comparisons = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(ird_pkg::OFF_BUSY, 32'hffffffff);
    rd(ird_pkg::OFF_MASK_ERR, 32'h4);
    rd(ird_pkg::OFF_INVEC, 32'h0);
    wr(ird_pkg::OFF_SEL, 32'h2);
    xc(2, 63);
    xc(2, 0);
    xc(2, 40);
    xc(2, 40);
    chk(rx_pending, 32'h4);
    rd(ird_pkg::OFF_RX_HI, 32'h80000100);
    rd(ird_pkg::OFF_INVEC, 32'h7f);
    rd(ird_pkg::OFF_INVEC, 32'h68);
    rd(ird_pkg::OFF_INVEC, 32'h40);
    rd(ird_pkg::OFF_INVEC, 32'h0);
    xc(2, 1);
    xc(2, 2);
    xc(2, 33);
    wr(ird_pkg::OFF_XCALL, 32'h10203);
    wr(ird_pkg::OFF_RX_LO, 32'hfffffffb);
    rd(ird_pkg::OFF_RX_LO, 32'h2);
    wr(ird_pkg::OFF_RX_LO, 32'h0);
    wr(ird_pkg::OFF_RX_HI, 32'h0);
    chk(rx_pending, 32'h0);
    pulse(4);
    wr(ird_pkg::OFF_SEL, 32'h1);
    rd(ird_pkg::OFF_RX_LO, 32'h8);
    wr(ird_pkg::OFF_RX_LO, 32'h0);
    wr(ird_pkg::OFF_MONDO_VEC, 32'h5);
    wr(ird_pkg::OFF_SEL, 32'h3);
    wr(ird_pkg::OFF_BUSY, 32'h9);
    rd(ird_pkg::OFF_BUSY, 32'hfffffff6);
    send(64'h12345678_9abcdef0);
    rd(ird_pkg::OFF_BUSY, 32'hfffffffe);
    rd(ird_pkg::OFF_PAY0_LO, 32'h9abcdef0);
    rd(ird_pkg::OFF_PAY1_HI, 32'hedcba987);
    rd(ird_pkg::OFF_RX_LO, 32'h20);
    send(64'h55);
    chk(32'(nacks > 0), 32'h1);
    rd(ird_pkg::OFF_PAY0_LO, 32'h9abcdef0);
    wr(ird_pkg::OFF_BUSY, 32'h8);
    repeat (3) @(posedge pclk);
    chk(32'(mondo_req.valid), 32'h0);
    rd(ird_pkg::OFF_PAY0_LO, 32'h55);
    wr(ird_pkg::OFF_SEL, 32'h1);
    wr(ird_pkg::OFF_ROUTE_SER, 32'h107);
    wr(ird_pkg::OFF_ROUTE_ERR, 32'h109);
    wr(ird_pkg::OFF_MASK_SER, 32'h0);
    pulse(3);
    rd(ird_pkg::OFF_RX_LO, 32'h80);
    rd(ird_pkg::OFF_MASK_SER, 32'h4);
    pulse(3);
    pulse(3);
    rd(ird_pkg::OFF_MASK_SER, 32'h5);
    wr(ird_pkg::OFF_RX_LO, 32'h0);
    wr(ird_pkg::OFF_MASK_SER, 32'h0);
    rd(ird_pkg::OFF_MASK_SER, 32'h4);
    rd(ird_pkg::OFF_RX_LO, 32'h80);
    wr(ird_pkg::OFF_MASK_SER, 32'h0);
    rd(ird_pkg::OFF_MASK_SER, 32'h0);
    for (int k = 0; k < 3; k++) begin
      // Two unmasks: a leftover pending event is delivered first, then the source idles
      wr(ird_pkg::OFF_MASK_ERR, 32'h0);
      wr(ird_pkg::OFF_MASK_ERR, 32'h0);
      wr(ird_pkg::OFF_RX_LO, 32'h0);
      pulse(k);
      rd(ird_pkg::OFF_RX_LO, 32'h200);
    end
    pulse(2);
    rd(ird_pkg::OFF_MASK_ERR, 32'h5);
    wr(ird_pkg::OFF_MASK_ERR, 32'h6);
    rd(ird_pkg::OFF_MASK_ERR, 32'h4);
    wr(ird_pkg::OFF_RX_LO, 32'h0);
    wr(ird_pkg::OFF_MASK_ERR, 32'h0);
    pulse(4);
    rd(ird_pkg::OFF_RX_LO, 32'h208);
    rd(12'h0f0, 32'h0);
    chk(32'(rd_e), 32'h1);
    summarize();
  end
endmodule
